// ---- rtl/addr_gen_pkg.sv ----
package addr_gen_pkg;

   // ----------------------------------------------------------------
   // widths and fixed values
   // ----------------------------------------------------------------
   localparam int          ADDR_W             = 16;
   localparam int          SEL_W              = 4;
   localparam logic [15:0] RESET_PC           = 16'h0000;
   localparam logic [15:0] PC_STEP            = 16'h0002;
   localparam logic [3:0]  ZERO_REG           = 4'h0;
   localparam logic [3:0]  STACK_POINTER_WORD = 4'hf;

   // ----------------------------------------------------------------
   // status line codes
   // ----------------------------------------------------------------
   localparam logic [3:0]  STATUS_INSTR       = 4'hc;
   localparam logic [3:0]  STATUS_DATA_DEF    = 4'h8;
   localparam logic [3:0]  STATUS_STACK_DEF   = 4'h9;
   localparam logic [3:0]  STATUS_STD_IO_DEF  = 4'h2;
   localparam logic [3:0]  STATUS_SPEC_IO_DEF = 4'h3;
   localparam logic [3:0]  STATUS_NONE_DEF    = 4'h0;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      register_mode,
      literal_operand_mode,
      pointer_register_mode,
      absolute_address_mode,
      index_mode,
      pc_offset_mode,
      base_mode,
      two_register_sum_mode
   } addr_mode_type;

   typedef enum logic [3:0] {
      cls_general,
      cls_std_io,
      cls_spec_io,
      cls_jump_call,
      cls_load,
      cls_load_effective,
      cls_pc_offset_jump,
      cls_decrement_jump_nonzero,
      cls_pc_offset_call,
      cls_pc_offset_load,
      cls_pc_offset_load_effective
   } inst_class_type;

   typedef enum logic [1:0] {
      byte_width,
      word_width,
      double_word_register,
      quad_word_register
   } width_type;

   typedef enum logic [1:0] {
      loc_register,
      loc_instruction,
      loc_memory,
      loc_program_counter
   } location_type;

   typedef struct packed {
      addr_mode_type    mode;
      inst_class_type   cls;
      width_type        width;
      logic             is_destination;
      logic [SEL_W-1:0] ptr_sel;
      logic [SEL_W-1:0] idx_sel;
      logic [15:0]      inst_word;
      logic [15:0]      ptr_value;
      logic [15:0]      idx_value;
   } request_type;

   typedef struct packed {
      location_type     location;
      logic [15:0]      ea;
      logic [3:0]       status;
      width_type        width;
      logic             pc_load;
      logic             invalid;
   } result_type;

endpackage

// ---- rtl/ea_adder.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------------
// effective address adder
// ------------------------------------------------------------------
module ea_adder #(
   parameter int WIDTH = 16
) (
   input  wire logic [WIDTH-1:0] base,
   input  wire logic [WIDTH-1:0] offset,
   output wire logic [WIDTH-1:0] sum
);

   logic [WIDTH:0] full;

   assign full = {1'b0, base} + {1'b0, offset};
   // carry dropped
   // the carry is thrown away so addresses wrap around the space
   assign sum  = full[WIDTH-1:0];

endmodule

// ---- rtl/operand_locator.sv ----
`timescale 1ns/1ps

// Summary of operation
// - register mode reads the named register; opcode fixes width.
// - immediate serves sources only; immediate destination is invalid.
// - immediate operands lie in program memory space.
// - indirect address is a whole word register, never register zero.
// - indirect space follows class: standard I/O, special I/O, memory.
// - indirect memory use via stack pointer word reports stack.
// - direct address comes from instruction; space follows class.
// - direct jump or call loads the instruction address into PC.
// - index address is instruction address plus index register.
// - any word register except register zero may index.
// - index operands in data space; jump or call targets in program.
// - relative address is updated PC plus signed displacement.
// - relative operands always lie in program memory space.
// - relative mode only for the five relative instruction kinds.
// - base address is base register plus instruction displacement.
// - base mode only for load and load address.
// - any word register except register zero may be base.
// - base mode reports stack when base is stack pointer word.
// - base-index adds base and index; load and load address only.
// - base-index accepts any register but zero in either role.
// - base-index reports stack when base is stack pointer word.
// - PC steps past each fetched word before relative sums use it.
// - relative operand cycles drive status code 1100.
module operand_locator #(
   parameter logic [3:0] STATUS_DATA    = addr_gen_pkg::STATUS_DATA_DEF,
   parameter logic [3:0] STATUS_STACK   = addr_gen_pkg::STATUS_STACK_DEF,
   parameter logic [3:0] STATUS_STD_IO  = addr_gen_pkg::STATUS_STD_IO_DEF,
   parameter logic [3:0] STATUS_SPEC_IO = addr_gen_pkg::STATUS_SPEC_IO_DEF,
   parameter logic [3:0] STATUS_NONE    = addr_gen_pkg::STATUS_NONE_DEF
) (
   input  wire logic                      mclk,
   input  wire logic                      rst,
   input  wire logic                      req_valid,
   input  wire addr_gen_pkg::request_type req,
   input  wire logic                      fetch_word,
   output      logic                      ans_valid,
   output      addr_gen_pkg::result_type  ans,
   output      logic [15:0]               pc
);

   // ----------------------------------------------------------------
   // register decoding helpers
   // ----------------------------------------------------------------
   function automatic logic is_stack(input logic [3:0] sel);
      return sel == addr_gen_pkg::STACK_POINTER_WORD;
   endfunction

   function automatic logic is_zero(input logic [3:0] sel);
      return sel == addr_gen_pkg::ZERO_REG;
   endfunction

   // ----------------------------------------------------------------
   // mode and class decode
   // ----------------------------------------------------------------
   wire logic is_reg;
   wire logic is_imm;
   wire logic is_ptr;
   wire logic is_abs;
   wire logic is_idx;
   wire logic is_rel;
   wire logic is_base;
   wire logic is_bx;
   wire logic std_io;
   wire logic spec_io;
   wire logic jump_call;
   wire logic load_class;
   wire logic rel_class;

   assign is_reg  = req.mode == addr_gen_pkg::register_mode;
   assign is_imm  = req.mode == addr_gen_pkg::literal_operand_mode;
   assign is_ptr  = req.mode == addr_gen_pkg::pointer_register_mode;
   assign is_abs  = req.mode == addr_gen_pkg::absolute_address_mode;
   assign is_idx  = req.mode == addr_gen_pkg::index_mode;
   assign is_rel  = req.mode == addr_gen_pkg::pc_offset_mode;
   assign is_base = req.mode == addr_gen_pkg::base_mode;
   assign is_bx   = req.mode == addr_gen_pkg::two_register_sum_mode;

   assign std_io     = req.cls == addr_gen_pkg::cls_std_io;
   assign spec_io    = req.cls == addr_gen_pkg::cls_spec_io;
   assign jump_call  = req.cls == addr_gen_pkg::cls_jump_call;
   assign load_class = req.cls == addr_gen_pkg::cls_load
                    || req.cls == addr_gen_pkg::cls_load_effective;
   assign rel_class  = req.cls == addr_gen_pkg::cls_pc_offset_jump
                    || req.cls == addr_gen_pkg::cls_decrement_jump_nonzero
                    || req.cls == addr_gen_pkg::cls_pc_offset_call
                    || req.cls == addr_gen_pkg::cls_pc_offset_load
                    || req.cls == addr_gen_pkg::cls_pc_offset_load_effective;

   // ----------------------------------------------------------------
   // program counter view
   // ----------------------------------------------------------------
   wire logic [15:0] pc_stepped;
   wire logic [15:0] pc_now;

   assign pc_stepped = 16'(pc + addr_gen_pkg::PC_STEP);
   // updated pc
   // a word fetched in the same cycle already counts, so the relative
   // base never lags the instruction stream
   assign pc_now     = fetch_word ? pc_stepped : pc;

   // ----------------------------------------------------------------
   // address operands
   // ----------------------------------------------------------------
   wire logic [15:0] op_a;
   wire logic [15:0] op_b;
   wire logic [15:0] sum;

   assign op_a = (is_rel || is_imm) ? pc_now :
                 (is_abs || is_idx) ? req.inst_word :
                 (is_ptr || is_base || is_bx) ? req.ptr_value :
                 16'h0000;
   assign op_b = (is_idx || is_bx) ? req.idx_value :
                 (is_base || is_rel) ? req.inst_word :
                 16'h0000;

   ea_adder #(
      .WIDTH  (addr_gen_pkg::ADDR_W)
   ) adder (
      .base   (op_a),
      .offset (op_b),
      .sum    (sum)
   );

   // ----------------------------------------------------------------
   // address space and status code
   // ----------------------------------------------------------------
   wire logic       ptr_stack;
   wire logic [3:0] class_status;
   wire logic [3:0] mem_status;
   wire logic [3:0] next_status;

   assign ptr_stack = is_stack(req.ptr_sel);

   assign class_status = std_io  ? STATUS_STD_IO :
                         spec_io ? STATUS_SPEC_IO :
                         STATUS_DATA;
   assign mem_status   = ptr_stack ? STATUS_STACK : STATUS_DATA;

   assign next_status =
      is_reg                     ? STATUS_NONE :
      (is_imm || is_rel)         ? addr_gen_pkg::STATUS_INSTR :
      ((is_abs || is_idx) && jump_call) ? addr_gen_pkg::STATUS_INSTR :
      (is_ptr && (std_io || spec_io))   ? class_status :
      is_ptr                     ? mem_status :
      is_abs                     ? class_status :
      is_idx                     ? STATUS_DATA :
      mem_status;

   // ----------------------------------------------------------------
   // operand location
   // ----------------------------------------------------------------
   wire addr_gen_pkg::location_type next_location;
   wire logic                       jump_take;

   assign jump_take = req_valid && jump_call && (is_abs || is_idx);

   assign next_location = is_reg ? addr_gen_pkg::loc_register :
                          is_imm ? addr_gen_pkg::loc_instruction :
                          (jump_call && (is_abs || is_idx)) ?
                             addr_gen_pkg::loc_program_counter :
                          addr_gen_pkg::loc_memory;

   // ----------------------------------------------------------------
   // illegal encodings
   // ----------------------------------------------------------------
   wire logic uses_ptr;
   wire logic uses_idx;
   wire logic bad_reg;
   wire logic bad_use;

   assign uses_ptr = is_ptr || is_base || is_bx;
   assign uses_idx = is_idx || is_bx;
   assign bad_reg  = (uses_ptr && is_zero(req.ptr_sel))
                  || (uses_idx && is_zero(req.idx_sel));
   assign bad_use  = (is_imm && req.is_destination)
                  || ((is_base || is_bx) && !load_class)
                  || (is_rel && !rel_class);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   wire addr_gen_pkg::result_type next_result;
   wire logic [15:0]              next_pc;

   assign next_result.location = next_location;
   assign next_result.ea       = sum;
   assign next_result.status   = next_status;
   assign next_result.width    = req.width;
   assign next_result.pc_load  = jump_call && (is_abs || is_idx);
   assign next_result.invalid  = bad_reg || bad_use;

   // a jump load wins over a fetch step in the same cycle
   // pc takes target
   assign next_pc = jump_take  ? sum :
                    fetch_word ? pc_stepped :
                    pc;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ans_valid <= 1'b0;
         ans       <= '0;
         pc        <= addr_gen_pkg::RESET_PC;
      end else begin
         ans_valid <= req_valid;
         if (req_valid) begin
            ans <= next_result;
         end
         pc <= next_pc;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking chk @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence rel_req;
      req_valid && is_rel;
   endsequence

   sequence ans_now;
      ans_valid;
   endsequence

   reg_location_a: assert property (
      req_valid && is_reg |=> ans_now and
         (ans.location == addr_gen_pkg::loc_register
          && ans.width == $past(req.width)))
      else $error("register mode operand not in register");

   imm_dest_a: assert property (
      req_valid && is_imm && req.is_destination |=> ans.invalid)
      else $error("immediate destination not flagged");

   imm_space_a: assert property (
      req_valid && is_imm |=>
         ans.status == addr_gen_pkg::STATUS_INSTR
         && ans.location == addr_gen_pkg::loc_instruction)
      else $error("immediate operand not in program space");

   ptr_address_a: assert property (
      req_valid && is_ptr |=> ans.ea == $past(req.ptr_value))
      else $error("indirect address differs from pointer");

   ptr_io_space_a: assert property (
      req_valid && is_ptr && (std_io || spec_io) |=>
         ans.status == ($past(std_io) ? STATUS_STD_IO : STATUS_SPEC_IO))
      else $error("indirect I/O space wrong");

   ptr_stack_a: assert property (
      req_valid && is_ptr && !std_io && !spec_io |=>
         ans.status == ($past(ptr_stack) ? STATUS_STACK : STATUS_DATA))
      else $error("indirect stack or data status wrong");

   direct_addr_a: assert property (
      req_valid && is_abs && !jump_call |=>
         ans.ea == $past(req.inst_word)
         && ans.status == $past(class_status))
      else $error("direct address or space wrong");

   direct_jump_a: assert property (
      req_valid && is_abs && jump_call |=>
         pc == $past(req.inst_word) && ans.pc_load)
      else $error("direct jump did not load pc");

   index_sum_a: assert property (
      req_valid && is_idx |=>
         ans.ea == $past(16'(req.inst_word + req.idx_value)))
      else $error("index address wrong");

   index_zero_a: assert property (
      req_valid && is_idx |=>
         ans.invalid == ($past(req.idx_sel) == addr_gen_pkg::ZERO_REG))
      else $error("index register check wrong");

   index_space_a: assert property (
      req_valid && is_idx |=> ans.status == ($past(jump_call) ?
         addr_gen_pkg::STATUS_INSTR : STATUS_DATA))
      else $error("index space wrong");

   rel_address_a: assert property (
      rel_req |=> ans.ea == $past(16'(pc_now + req.inst_word)))
      else $error("relative address wrong");

   rel_space_a: assert property (
      rel_req |=> ans.location == addr_gen_pkg::loc_memory)
      else $error("relative operand not in memory");

   rel_class_a: assert property (
      rel_req and !rel_class |=> ans.invalid)
      else $error("relative mode outside allowed kinds");

   base_sum_a: assert property (
      req_valid && is_base |=>
         ans.ea == $past(16'(req.ptr_value + req.inst_word)))
      else $error("base address wrong");

   base_class_a: assert property (
      req_valid && is_base && !load_class |=> ans.invalid)
      else $error("base mode outside load not flagged");

   base_zero_a: assert property (
      req_valid && is_base && load_class |=>
         ans.invalid == ($past(req.ptr_sel) == addr_gen_pkg::ZERO_REG))
      else $error("base register check wrong");

   base_stack_a: assert property (
      req_valid && is_base |=>
         ans.status == ($past(ptr_stack) ? STATUS_STACK : STATUS_DATA))
      else $error("base status wrong");

   bx_sum_a: assert property (
      req_valid && is_bx |=>
         ans.ea == $past(16'(req.ptr_value + req.idx_value)))
      else $error("base-index address wrong");

   bx_zero_a: assert property (
      req_valid && is_bx && load_class && is_zero(req.idx_sel)
         |=> ans.invalid)
      else $error("base-index zero register not flagged");

   bx_stack_a: assert property (
      req_valid && is_bx |=>
         ans.status == ($past(ptr_stack) ? STATUS_STACK : STATUS_DATA))
      else $error("base-index status wrong");

   pc_step_a: assert property (
      fetch_word && !jump_take ##1 fetch_word && !jump_take
         |=> pc == 16'($past(pc, 2) + 16'h0004))
      else $error("pc did not step by two per word");

   rel_status_a: assert property (
      rel_req |=> ans_now and ans.status == 4'hc)
      else $error("relative status not 1100");

   wrap_sum_a: assert property (
      req_valid && is_bx && req.ptr_value == 16'hffff
         && req.idx_value == 16'h0002 |=> ans.ea == 16'h0001)
      else $error("address did not wrap");

   ptr_zero_a: assert property (
      req_valid && is_ptr && is_zero(req.ptr_sel) |=> ans.invalid)
      else $error("zero pointer register not flagged");

   valid_pulse_a: assert property (
      !req_valid |=> !ans_valid)
      else $error("answer without request");

endmodule

// ---- bench/reg_file_model.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// word register file on the decode side
// ------------------------------------------------------------
module reg_file_model (
   input  wire logic        mclk,
   input  wire logic        wr_en,
   input  wire logic [3:0]  wr_sel,
   input  wire logic [15:0] wr_data,
   input  wire logic [3:0]  a_sel,
   input  wire logic [3:0]  b_sel,
   output wire logic [15:0] a_value,
   output wire logic [15:0] b_value
);
   logic [15:0] regs [16];

   // reads are combinational: the values go out with the request
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         regs[wr_sel] <= wr_data;
      end
   end
   assign a_value = regs[a_sel];
   assign b_value = regs[b_sel];
endmodule

// ---- bench/operand_locator_tb.sv ----
`timescale 1ns/1ps

module operand_locator_tb;
   logic        mclk = 0, rst = 1, req_valid = 0, fetch_word = 0;
   logic        wr_en = 0;
   logic [3:0]  wr_sel = 0;
   logic [15:0] wr_data = 0, pc_m = 0, a_value, b_value, pc;
   logic [15:0] shadow [16];
   addr_gen_pkg::request_type req_drv = '0, req_bus;
   addr_gen_pkg::result_type  ans, exp_q [$];
   logic [15:0] pc_q [$];
   logic        ans_valid;
   int          mismatches = 0, comparisons = 0, seed = 32'h7cc6;

   always #5 mclk = ~mclk;

   // ------------------------------------------------------------
   // design and partner
   // ------------------------------------------------------------
   always_comb begin
      req_bus = req_drv;
      req_bus.ptr_value = a_value;
      req_bus.idx_value = b_value;
   end
   operand_locator i_dut (.mclk(mclk), .rst(rst), .req_valid(req_valid),
      .req(req_bus), .fetch_word(fetch_word), .ans_valid(ans_valid),
      .ans(ans), .pc(pc));
   reg_file_model i_regs (.mclk(mclk), .wr_en(wr_en), .wr_sel(wr_sel),
      .wr_data(wr_data), .a_sel(req_drv.ptr_sel), .b_sel(req_drv.idx_sel),
      .a_value(a_value), .b_value(b_value));

   // ------------------------------------------------------------
   // expectation
   // ------------------------------------------------------------
   function automatic addr_gen_pkg::result_type exp_of(
      input addr_gen_pkg::request_type r,
      input logic [15:0]               pn);
      addr_gen_pkg::result_type e;
      logic                     ld, jc;
      e = '0;
      e.width = r.width;
      e.location = addr_gen_pkg::loc_memory;
      ld = (r.cls == addr_gen_pkg::cls_load)
        || (r.cls == addr_gen_pkg::cls_load_effective);
      jc = r.cls == addr_gen_pkg::cls_jump_call;
      e.status = r.cls == addr_gen_pkg::cls_std_io ?
                    addr_gen_pkg::STATUS_STD_IO_DEF :
                 r.cls == addr_gen_pkg::cls_spec_io ?
                    addr_gen_pkg::STATUS_SPEC_IO_DEF :
                    addr_gen_pkg::STATUS_DATA_DEF;
      case (r.mode)
         addr_gen_pkg::register_mode: begin
            e.location = addr_gen_pkg::loc_register;
            e.status = addr_gen_pkg::STATUS_NONE_DEF;
         end
         addr_gen_pkg::literal_operand_mode: begin
            e.location = addr_gen_pkg::loc_instruction;
            e.ea = pn;
            e.status = 4'hc;
            e.invalid = r.is_destination;
         end
         addr_gen_pkg::pointer_register_mode: begin
            e.ea = r.ptr_value;
            if (e.status == addr_gen_pkg::STATUS_DATA_DEF
                && r.ptr_sel == 4'hf) begin
               e.status = addr_gen_pkg::STATUS_STACK_DEF;
            end
            e.invalid = r.ptr_sel == 4'h0;
         end
         addr_gen_pkg::absolute_address_mode,
         addr_gen_pkg::index_mode: begin
            e.ea = r.inst_word;
            if (r.mode == addr_gen_pkg::index_mode) begin
               e.ea = r.inst_word + r.idx_value;
               e.status = addr_gen_pkg::STATUS_DATA_DEF;
               e.invalid = r.idx_sel == 4'h0;
            end
            if (jc) begin
               e.pc_load = 1'b1;
               e.location = addr_gen_pkg::loc_program_counter;
               e.status = 4'hc;
            end
         end
         addr_gen_pkg::pc_offset_mode: begin
            e.ea = pn + r.inst_word;
            e.status = 4'hc;
            e.invalid = r.cls < addr_gen_pkg::cls_pc_offset_jump;
         end
         default: begin
            e.ea = r.ptr_value + (r.mode == addr_gen_pkg::base_mode ?
                                  r.inst_word : r.idx_value);
            e.status = r.ptr_sel == 4'hf ? addr_gen_pkg::STATUS_STACK_DEF
                                         : addr_gen_pkg::STATUS_DATA_DEF;
            e.invalid = r.ptr_sel == 4'h0 || !ld ||
                        (r.mode != addr_gen_pkg::base_mode
                         && r.idx_sel == 4'h0);
         end
      endcase
      return e;
   endfunction

   // ------------------------------------------------------------
   // driver
   // ------------------------------------------------------------
   task automatic send(input addr_gen_pkg::request_type r,
                       input logic fw, input logic v);
      addr_gen_pkg::result_type e;
      logic [15:0] pn;
      @(posedge mclk);
      r.ptr_value = shadow[r.ptr_sel];
      r.idx_value = shadow[r.idx_sel];
      req_drv <= r;
      req_valid <= v;
      fetch_word <= fw;
      pn = fw ? pc_m + 16'h0002 : pc_m;
      e = exp_of(r, pn);
      pc_m = (v && e.pc_load) ? e.ea : pn;
      if (v) begin
         exp_q.push_back(e);
         pc_q.push_back(pc_m);
      end
   endtask

   task automatic rand_req(output addr_gen_pkg::request_type r);
      logic [95:0] b;
      b = {$random(seed), $random(seed), $random(seed)};
      r = b[65:0];
      r.cls = addr_gen_pkg::inst_class_type'(
                 4'($unsigned($random(seed)) % 11));
      if (r.mode == addr_gen_pkg::index_mode && r.idx_sel == 4'h0) begin
         r.idx_sel = 4'h1;
      end
   endtask

   task automatic give_verdict;
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic ok, input string what);
      comparisons++;
      if (!ok) begin
         mismatches++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask

   // ------------------------------------------------------------
   // monitor
   // ------------------------------------------------------------
   always @(negedge mclk) begin
      addr_gen_pkg::result_type e;
      logic [15:0] p;
      if (rst === 1'b0 && ans_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(1'b0, "answer without request");
         end else begin
            e = exp_q.pop_front();
            p = pc_q.pop_front();
            check(ans.ea === e.ea, "address");
            check(ans.status === e.status, "status code");
            check(ans.location === e.location, "location");
            check(ans.invalid === e.invalid, "invalid flag");
            check(ans.width === e.width, "width");
            check(ans.pc_load === e.pc_load, "pc load");
            check(pc === p, "program counter");
         end
      end
   end

   initial begin
      #100us;
      mismatches++;
      give_verdict();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      addr_gen_pkg::request_type r;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         @(posedge mclk);
         wr_en <= 1'b1;
         wr_sel <= 4'(i);
         shadow[i] = (i == 15) ? 16'hfff0 : 16'($random(seed));
         wr_data <= shadow[i];
      end
      @(posedge mclk);
      wr_en <= 1'b0;
      check(pc === 16'h0000 && ans_valid === 1'b0, "reset state");
      // every mode with every class, back to back
      for (int m = 0; m < 8; m++) begin
         for (int c = 0; c < 11; c++) begin
            rand_req(r);
            r.mode = addr_gen_pkg::addr_mode_type'(3'(m));
            r.cls = addr_gen_pkg::inst_class_type'(4'(c));
            send(r, c[0], 1'b1);
         end
      end
      for (int i = 0; i < 400; i++) begin
         rand_req(r);
         send(r, $random(seed) & 1, $random(seed) & 1);
      end
      send(r, 1'b0, 1'b0);
      // carry dropped: ffff plus 0002 lands on 0001
      wr_en <= 1'b1;
      wr_sel <= 4'h1;
      wr_data <= 16'hffff;
      @(posedge mclk);
      wr_sel <= 4'h2;
      wr_data <= 16'h0002;
      @(posedge mclk);
      wr_en <= 1'b0;
      shadow[1] = 16'hffff;
      shadow[2] = 16'h0002;
      r = '0;
      r.mode = addr_gen_pkg::two_register_sum_mode;
      r.cls = addr_gen_pkg::cls_load;
      r.ptr_sel = 4'h1;
      r.idx_sel = 4'h2;
      send(r, 1'b0, 1'b1);
      send(r, 1'b0, 1'b0);
      repeat (2) @(posedge mclk);
      rst <= 1'b1;
      pc_m = 16'h0000;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      check(pc === 16'h0000 && ans === '0, "second reset");
      for (int i = 0; i < 50; i++) begin
         rand_req(r);
         send(r, $random(seed) & 1, 1'b1);
      end
      send(r, 1'b0, 1'b0);
      repeat (3) @(posedge mclk);
      check(pc === pc_m && exp_q.size() == 0, "final pc");
      give_verdict();
   end
endmodule
